/* File: bench/tb.sv */
// self-checking bench for the valve driver two message block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic dis; logic fb; logic [3:0] flg; logic [9:0] pl;
        logic bad; logic [9:0] exp; logic perr;} vdt_row_t;
    logic ref_clk_i = 1'h0;
    logic rstn_i = 1'h0;
    logic spi_cs_n_i, spi_sclk_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o;
    logic pair_one_two_regulation_disable_i = 1'h0;
    logic readback_feedback_select_i = 1'h0;
    logic [3:0] flg = 4'h0;
    logic [7:0] regulator_duty_i = 8'h5a;
    logic [9:0] adc_current_i = 10'h2c7;
    logic [9:0] current_target_o;
    logic [7:0] pwm_duty_o;
    logic target_write_o, duty_write_o, duty_reject_o, parity_error_o;
    logic [15:0] rx, want;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    int n_target = 0;
    int n_duty = 0;
    int n_reject = 0;
    // mode, select, flags, payload, bad parity, readback, parity error
    vdt_row_t rows [8] = '{
        '{1'h0, 1'h0, 4'h0, 10'h3a5, 1'h0, 10'h3a5, 1'h0},
        '{1'h0, 1'h1, 4'h8, 10'h155, 1'h0, 10'h168, 1'h0},
        '{1'h1, 1'h0, 4'h4, 10'h0bb, 1'h0, 10'h0b8, 1'h0},
        '{1'h1, 1'h1, 4'h2, 10'h3ff, 1'h0, 10'h2c7, 1'h0},
        '{1'h1, 1'h0, 4'h1, 10'h064, 1'h0, 10'h3fc, 1'h0},
        '{1'h0, 1'h0, 4'hf, 10'h2aa, 1'h1, 10'h155, 1'h1},
        '{1'h1, 1'h0, 4'h0, 10'h394, 1'h0, 10'h394, 1'h0},
        '{1'h1, 1'h0, 4'h0, 10'h000, 1'h0, 10'h000, 1'h0}};

    vdt_msg DUT (
        .ref_clk_i, .rstn_i, .spi_cs_n_i, .spi_sclk_i, .spi_mosi_i, .spi_miso_o, .spi_miso_oe_o,
        .pair_one_two_regulation_disable_i, .readback_feedback_select_i,
        .driver_two_overcurrent_flag_i(flg[3]), .driver_two_open_load_flag_i(flg[2]),
        .driver_two_overtemp_flag_i(flg[1]), .driver_two_drain_voltage_flag_i(flg[0]),
        .regulator_duty_i, .adc_current_i, .current_target_o, .pwm_duty_o,
        .target_write_o, .duty_write_o, .duty_reject_o, .parity_error_o
    );
    vdt_host host (
        .spi_cs_n_o(spi_cs_n_i), .spi_sclk_o(spi_sclk_i), .spi_mosi_o(spi_mosi_i),
        .spi_miso_i(spi_miso_o), .spi_miso_oe_i(spi_miso_oe_o)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    always #20 ref_clk_i = ~ref_clk_i;

    function automatic logic [15:0] frame(input logic [4:0] id, input logic [9:0] pl,
        input logic bad);
        frame = {(~^{id, pl}) ^ bad, id, pl};
    endfunction : frame

    function automatic logic [15:0] resp(input logic pe, input logic [3:0] f,
        input logic [9:0] pl);
        resp = {~^{pe, f, pl}, pe, f, pl};
    endfunction : resp

    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #2;
    endtask : tick

    task automatic reset_check();
        rstn_i = 1'h0;
        tick(3);
        check("reset state", {current_target_o, pwm_duty_o, spi_miso_oe_o, parity_error_o},
            20'h00000);
        rstn_i = 1'h1;
        tick(3);
    endtask : reset_check

    task automatic print_verdict();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    // store pulses counted mid-cycle, where they stand settled
    always @(negedge ref_clk_i)
    begin
        if (target_write_o === 1'b1)
            n_target++;
        if (duty_write_o === 1'b1)
            n_duty++;
        if (duty_reject_o === 1'b1)
            n_reject++;
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        reset_check();
        $display("reset done");
        // second frame of a pair repeats the first, so its answer shows the first one's outcome
        foreach (rows[i])
        begin
            pair_one_two_regulation_disable_i = rows[i].dis;
            readback_feedback_select_i = rows[i].fb;
            flg = rows[i].flg;
            host.xfer(frame(5'h0b, rows[i].pl, rows[i].bad), 16, rx);
            host.xfer(frame(5'h0b, rows[i].pl, rows[i].bad), 16, rx);
            want = resp(rows[i].perr, rows[i].flg, rows[i].exp);
            check("response", {4'h0, rx}, {4'h0, want});
            check("parity flag", {19'h0, parity_error_o}, {19'h0, rows[i].perr});
            $display("row %0d done", i);
        end
        check("target writes", 20'(n_target), 20'h00004);
        check("duty writes", 20'(n_duty), 20'h00008);
        check("duty rejects", 20'(n_reject), 20'h00002);
        for (int k = 0; k < 2; k++)
        begin
            host.xfer(frame(k ? 5'h0b : 5'h0c, 10'h2aa, 1'h0), 16 - k, rx);
            check("duty kept", {12'h000, pwm_duty_o}, 20'h00000);
            host.xfer(frame(5'h0b, 10'h000, 1'h0), 16, rx);
            check("no answer", {19'h0, host.seen_oe}, 20'h00000);
        end
        $display("refused frames done");
        reset_check();
        host.xfer(frame(5'h0b, 10'h064, 1'h0), 16, rx);
        check("answer after reset", {19'h0, host.seen_oe}, 20'h00000);
        $display("mid-run reset done");
        print_verdict();
    end
endmodule : tb

/* File: bench/vdt_host.sv */
// host serial master model that sends valve driver two frames
module vdt_host (
    output logic spi_cs_n_o,
    output logic spi_sclk_o,
    output logic spi_mosi_o,
    input wire logic spi_miso_i,
    input wire logic spi_miso_oe_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic seen_oe = 1'h0;
    logic line_q = 1'h0;
    initial
    begin
        spi_cs_n_o = 1'h1;
        spi_sclk_o = 1'h0;
        spi_mosi_o = 1'h0;
    end

    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        seen_oe = 1'h0;
        spi_cs_n_o = 1'h0;
        #320;
        for (int i = 15; i > 15 - nbits; i--)
        begin
            spi_mosi_o = tx[i];
            #160;
            // a released line shows the inverse of its last level, never a stale copy
            line_q = spi_miso_oe_i ? spi_miso_i : ~line_q;
            seen_oe = seen_oe | spi_miso_oe_i;
            rx = {rx[14:0], line_q};
            spi_sclk_o = 1'h1;
            #160;
            spi_sclk_o = 1'h0;
        end
        #160;
        spi_cs_n_o = 1'h1;
        // long gap so the store and pulses land before the next frame
        #800;
    endtask : xfer
endmodule : vdt_host

/* File: bench/vdt_msg_chk.sv */
// port assertions for the valve driver two message block
module vdt_msg_chk (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_miso_oe_o,
    input wire logic pair_one_two_regulation_disable_i,
    input wire logic [9:0] current_target_o,
    input wire logic [7:0] pwm_duty_o,
    input wire logic target_write_o,
    input wire logic duty_write_o,
    input wire logic duty_reject_o,
    input wire logic parity_error_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_cs_idle;
        spi_cs_n_i [*6];
    endsequence
    sequence s_store;
        target_write_o || duty_write_o;
    endsequence

    a_oe_idle_off: assert property (s_cs_idle |-> !spi_miso_oe_o)
        else $error("answer enable high outside a frame");
    a_store_one_pulse: assert property (s_store |=> !(target_write_o || duty_write_o))
        else $error("store pulse longer than one cycle");
    a_pulses_exclusive: assert property ($onehot0({target_write_o, duty_write_o, duty_reject_o}))
        else $error("two store pulses at once");
    a_target_on_write: assert property ($changed(current_target_o) |-> target_write_o)
        else $error("target changed without a write");
    a_duty_on_write: assert property ($changed(pwm_duty_o) |-> duty_write_o)
        else $error("duty changed without a write");
    a_duty_code_legal: assert property (duty_write_o |->
        pwm_duty_o inside {8'h00, 8'hff, [8'h1a:8'he5]})
        else $error("illegal duty stored");
    a_target_mode: assert property (target_write_o |->
        !pair_one_two_regulation_disable_i)
        else $error("target written in pwm mode");
    a_duty_mode: assert property ((duty_write_o || duty_reject_o) |->
        pair_one_two_regulation_disable_i)
        else $error("duty handled in current mode");
    a_no_late_pulse: assert property (spi_cs_n_i [*8] |->
        !(target_write_o || duty_write_o || duty_reject_o))
        else $error("store pulse long after frame end");
    a_perr_at_close: assert property ($changed(parity_error_o) |-> spi_cs_n_i)
        else $error("parity flag changed inside a frame");
endmodule : vdt_msg_chk

bind vdt_msg vdt_msg_chk u_chk (
    .ref_clk_i, .rstn_i, .spi_cs_n_i, .spi_miso_oe_o, .pair_one_two_regulation_disable_i,
    .current_target_o, .pwm_duty_o, .target_write_o, .duty_write_o, .duty_reject_o,
    .parity_error_o
);

/* File: core/vdt_defs.svh */
// constants for the valve driver two serial message block
`ifndef VDT_DEFS_SVH
`define VDT_DEFS_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define VDT_FRAME_BITS 16
`define VDT_CNT_W 5
`define VDT_PARITY_BIT 15
`define VDT_ID_HI 14
`define VDT_ID_LO 10
`define VDT_FLAG_PERR_BIT 14
`define VDT_FLAG_OC_BIT 13
`define VDT_FLAG_OPEN_BIT 12
`define VDT_FLAG_OT_BIT 11
`define VDT_FLAG_VDS_BIT 10
`define VDT_PAYLOAD_HI 9
`define VDT_PAYLOAD_LO 0
`define VDT_FRAME_ID 5'h0b
`define VDT_FRAME_LEN 5'h10

// ----------------------------------------------------------------
// parity and duty limits
// ----------------------------------------------------------------
// 1'b1: a correct frame holds an odd number of ones over all 16 bits
`define VDT_PARITY_ODD 1'b1
`define VDT_DUTY_OFF 8'h00
`define VDT_DUTY_FULL 8'hff
// 26/255 is the first code at or above 10 %, 229/255 the last at or below 90 %
`define VDT_DUTY_MIN 8'h1a
`define VDT_DUTY_MAX 8'he5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define VDT_TARGET_RST 10'h000
`define VDT_DUTY_RST 8'h00
`define VDT_SYNC_RST 3'h5

`endif

/* File: core/vdt_msg.sv */
// serial command interpreter for valve driver two: decode, store and answer
`include "vdt_defs.svh"

// Summary of operation
// (RL1) frame is parity bit 15, identifier 01011 in 14:10, payload 9:0
// (RL2) response bit 14 low when previous frame parity was correct
// (RL3) response bit 14 high when previous frame had a parity error
// (RL4) response bit 13 reports overcurrent shutdown of driver two
// (RL5) response bit 12 reports open load on driver two
// (RL6) response bit 11 reports overtemperature shutdown of driver two
// (RL7) response bit 10 reports drain voltage detection, information only
// (RL8) regulation enabled: write stores 10-bit current target, any feedback select
// (RL9) regulation disabled: write stores upper 8 payload bits as duty
// (RL10) in pwm mode the two lowest written payload bits are ignored
// (RL11) regulation on, select 0: read returns stored current target
// (RL12) regulation on, select 1: read returns regulator output duty
// (RL13) regulation off, select 0: read returns programmed pwm duty
// (RL14) returned programmed duty has payload bits 1:0 at zero
// (RL15) regulation off, select 1: read returns 10-bit adc current
// (RL16) every 16-bit frame with identifier 01011 is parity checked, result reported in next response
module vdt_msg (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    input wire logic pair_one_two_regulation_disable_i,
    input wire logic readback_feedback_select_i,
    input wire logic driver_two_overcurrent_flag_i,
    input wire logic driver_two_open_load_flag_i,
    input wire logic driver_two_overtemp_flag_i,
    input wire logic driver_two_drain_voltage_flag_i,
    input wire logic [7:0] regulator_duty_i,
    input wire logic [9:0] adc_current_i,
    output logic [9:0] current_target_o,
    output logic [7:0] pwm_duty_o,
    output logic target_write_o,
    output logic duty_write_o,
    output logic duty_reject_o,
    output logic parity_error_o
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // parity bit that makes a 15-bit body a correct frame
    function automatic logic parity_of(input logic [14:0] body);
        parity_of = (^body) ^ `VDT_PARITY_ODD;
    endfunction : parity_of

    // the duty codes the output stage accepts
    function automatic logic duty_ok(input logic [7:0] duty);
        duty_ok = (duty == `VDT_DUTY_OFF) || (duty == `VDT_DUTY_FULL)
            || ((duty >= `VDT_DUTY_MIN) && (duty <= `VDT_DUTY_MAX));
    endfunction : duty_ok

    // ----------------------------------------------------------------
    // pin synchronisation and edge detection
    // ----------------------------------------------------------------
    logic [2:0] pins_s;
    logic cs_n_s;
    logic sclk_s;
    logic mosi_s;
    logic cs_n_prev_q;
    logic sclk_prev_q;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;

    vdt_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .async_i({spi_cs_n_i, spi_sclk_i, spi_mosi_i}),
        .sync_o(pins_s)
    );

    assign cs_n_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign mosi_s = pins_s[0];

    // previous levels reset to the idle pin levels, so release shows no false edge
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cs_n_prev_q <= 1'b1;
            sclk_prev_q <= 1'b0;
        end
        else
        begin
            cs_n_prev_q <= cs_n_s;
            sclk_prev_q <= sclk_s;
        end
    end

    assign cs_fall = cs_n_prev_q && !cs_n_s;
    assign cs_rise = !cs_n_prev_q && cs_n_s;
    assign sclk_rise = !sclk_prev_q && sclk_s && !cs_n_s;
    assign sclk_fall = sclk_prev_q && !sclk_s && !cs_n_s;

    // ----------------------------------------------------------------
    // frame sequencing
    // ----------------------------------------------------------------
    vdt_pkg::vdt_state_t state_q;
    vdt_pkg::vdt_state_t state_d;
    logic [`VDT_CNT_W-1:0] bit_cnt_q;
    logic in_shift;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            vdt_pkg::VDT_IDLE:
                if (cs_fall)
                    state_d = vdt_pkg::VDT_SHIFT;
            vdt_pkg::VDT_SHIFT:
                if (cs_rise)
                    state_d = vdt_pkg::VDT_CLOSE;
            vdt_pkg::VDT_CLOSE:
                state_d = vdt_pkg::VDT_IDLE;
            default:
                state_d = vdt_pkg::VDT_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            state_q <= vdt_pkg::VDT_IDLE;
        else
            state_q <= state_d;
    end

    assign in_shift = (state_q == vdt_pkg::VDT_SHIFT);

    // saturates one past a full frame so long frames stay detectable
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            bit_cnt_q <= '0;
        else if (cs_fall)
            bit_cnt_q <= '0;
        else if (in_shift && sclk_rise && (bit_cnt_q <= `VDT_FRAME_LEN))
            bit_cnt_q <= bit_cnt_q + `VDT_CNT_W'(1);
    end

    // ----------------------------------------------------------------
    // response assembly and shifting
    // ----------------------------------------------------------------
    logic resp_valid_q;
    logic parity_err_q;
    logic [9:0] resp_payload;
    vdt_pkg::vdt_resp_t resp;
    logic [15:0] rx_word;
    logic tx_bit;
    vdt_pkg::vdt_frame_t frame;

    always_comb
    begin
        case ({pair_one_two_regulation_disable_i, readback_feedback_select_i})
            // (RL11) current target readback
            2'b00: resp_payload = current_target_o;
            // (RL12) regulator output duty
            2'b01: resp_payload = {regulator_duty_i, 2'b00};
            // (RL13) (RL14) programmed duty, low bits zero
            2'b10: resp_payload = {pwm_duty_o, 2'b00};
            // (RL15) measured current
            2'b11: resp_payload = adc_current_i;
            default: resp_payload = 10'h000;
        endcase
    end

    always_comb
    begin
        // (RL2) (RL3) previous frame parity status
        resp.parity_error = parity_err_q;
        // (RL4) (RL5) (RL6) (RL7) live fault flags
        resp.faults.overcurrent = driver_two_overcurrent_flag_i;
        resp.faults.open_load = driver_two_open_load_flag_i;
        resp.faults.overtemp = driver_two_overtemp_flag_i;
        resp.faults.drain_voltage = driver_two_drain_voltage_flag_i;
        resp.payload = resp_payload;
        // (RL1) response carries its own parity
        resp.parity = parity_of({resp.parity_error, resp.faults, resp.payload});
    end

    // the response is frozen at chip select so a flag that moves mid-frame
    // cannot tear the word on the wire
    vdt_shift u_shift (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .load_i(cs_fall),
        .tx_word_i(resp),
        .sample_i(in_shift && sclk_rise),
        .rx_bit_i(mosi_s),
        .advance_i(in_shift && sclk_fall && (bit_cnt_q != '0)),
        .rx_word_o(rx_word),
        .tx_bit_o(tx_bit)
    );

    assign frame = rx_word;

    // only answer when the previous frame addressed this driver, the
    // other message decoders own the data line otherwise
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            spi_miso_o <= 1'b0;
            spi_miso_oe_o <= 1'b0;
        end
        else
        begin
            spi_miso_o <= (in_shift || cs_fall) ? tx_bit : 1'b0;
            spi_miso_oe_o <= resp_valid_q && !cs_n_s && (in_shift || cs_fall);
        end
    end

    // ----------------------------------------------------------------
    // frame evaluation
    // ----------------------------------------------------------------
    logic closing;
    logic len_ok;
    logic id_ok;
    logic par_ok;
    logic accept;

    assign closing = (state_q == vdt_pkg::VDT_CLOSE);
    assign len_ok = (bit_cnt_q == `VDT_FRAME_LEN);
    // (RL1) identifier match
    assign id_ok = (frame.frame_identifier == `VDT_FRAME_ID);
    // (RL16) parity check
    assign par_ok = (frame.parity == parity_of(rx_word[14:0]));
    // a refused frame leaves both stored setpoints untouched
    assign accept = closing && len_ok && id_ok && par_ok;

    // (RL16) result held for next response
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            resp_valid_q <= 1'b0;
            parity_err_q <= 1'b0;
        end
        else if (closing)
        begin
            resp_valid_q <= len_ok && id_ok;
            if (len_ok && id_ok)
                parity_err_q <= !par_ok;
        end
    end

    assign parity_error_o = parity_err_q;

    // ----------------------------------------------------------------
    // setpoint storage
    // ----------------------------------------------------------------
    logic pwm_mode;
    logic [7:0] new_duty;

    assign pwm_mode = pair_one_two_regulation_disable_i;
    // (RL9) (RL10) duty from bits 9:2, 1:0 dropped
    assign new_duty = frame.payload[9:2];

    // (RL8) current target write
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            current_target_o <= `VDT_TARGET_RST;
        else if (accept && !pwm_mode)
            current_target_o <= frame.payload;
    end

    // (RL9) duty write, invalid codes keep the old duty
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pwm_duty_o <= `VDT_DUTY_RST;
        else if (accept && pwm_mode && duty_ok(new_duty))
            pwm_duty_o <= new_duty;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            target_write_o <= 1'b0;
            duty_write_o <= 1'b0;
            duty_reject_o <= 1'b0;
        end
        else
        begin
            target_write_o <= accept && !pwm_mode;
            duty_write_o <= accept && pwm_mode && duty_ok(new_duty);
            duty_reject_o <= accept && pwm_mode && !duty_ok(new_duty);
        end
    end

endmodule : vdt_msg

/* File: core/vdt_pkg.sv */
// types shared by the valve driver two serial message block
package vdt_pkg;

    typedef struct packed {
        logic overcurrent;
        logic open_load;
        logic overtemp;
        logic drain_voltage;
    } vdt_fault_t;

    typedef struct packed {
        logic parity;
        logic [4:0] frame_identifier;
        logic [9:0] payload;
    } vdt_frame_t;

    typedef struct packed {
        logic parity;
        logic parity_error;
        vdt_fault_t faults;
        logic [9:0] payload;
    } vdt_resp_t;

    typedef enum logic [2:0] {
        VDT_IDLE = 3'b001,
        VDT_SHIFT = 3'b010,
        VDT_CLOSE = 3'b100
    } vdt_state_t;

endpackage : vdt_pkg

/* File: core/vdt_shift.sv */
// 16-bit receive and transmit shift registers of the serial link
module vdt_shift (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic load_i,
    input wire logic [15:0] tx_word_i,
    input wire logic sample_i,
    input wire logic rx_bit_i,
    input wire logic advance_i,
    output logic [15:0] rx_word_o,
    output logic tx_bit_o
);

    logic [15:0] tx_q;

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            tx_q <= 16'h0000;
        else if (load_i)
            tx_q <= tx_word_i;
        else if (advance_i)
            tx_q <= {tx_q[14:0], 1'b0};
    end

    // msb first in both directions
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rx_word_o <= 16'h0000;
        else if (load_i)
            rx_word_o <= 16'h0000;
        else if (sample_i)
            rx_word_o <= {rx_word_o[14:0], rx_bit_i};
    end

    assign tx_bit_o = tx_q[15];

endmodule : vdt_shift

/* File: core/vdt_sync.sv */
// two flip-flop synchroniser for the serial pins
`include "vdt_defs.svh"
module vdt_sync (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [2:0] async_i,
    output logic [2:0] sync_o
);

    logic [2:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_q <= `VDT_SYNC_RST;
            sync_o <= `VDT_SYNC_RST;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : vdt_sync
